// ===== hdl/mcr_router.sv
// Channel message router between local controls, sequencer, tone generator and the external link.
// Assumes byte framing is done outside; all inputs come from logic on clk, so none is synchronised.
`include "mcr_regs.svh"

module mcr_router (
   // Clock, synchronous reset and clock enable.
   input logic clk,
   input logic rst,
   input logic ce,
   // Global configuration.
   input mcr_pkg::mcr_mode_t mode,
   input logic [3:0] global_chan,
   input logic play_page,
   input logic local_ctrl_on,
   input logic pc_all_en,
   input logic combi_change_en,
   input logic bank_en,
   input logic at_en,
   input logic cc_en,
   input logic [6:0] bank_map_gen_msb,
   input logic [3:0] sel_track,
   // Per-part configuration, part i in the i-th field.
   input logic [63:0] part_chan,
   input logic [31:0] part_status,
   input logic [15:0] part_pc_en,
   input logic [15:0] part_at_en,
   input logic [15:0] stick_up_permit,
   input logic [15:0] part_asg_en,
   input logic [15:0] part_other_en,
   input logic [6:0] asg_cc,
   input logic [11:0] effect_control_channel,
   input logic [127:0] part_pnum,
   input logic [15:0] part_gen,
   input logic [223:0] part_bank,
   // Received channel messages from the link.
   input logic rx_valid,
   input logic [7:0] rx_status,
   input logic [6:0] rx_d1,
   input logic [6:0] rx_d2,
   // Accepted messages toward the tone generator.
   output logic acc_valid,
   output logic [7:0] acc_status,
   output logic [6:0] acc_d1,
   output logic [6:0] acc_d2,
   output logic [15:0] acc_mask,
   output logic acc_global,
   output logic [2:0] acc_fx,
   // Program selection results.
   output logic prog_valid,
   output logic prog_combi,
   output logic [13:0] prog_bank,
   output logic [7:0] prog_num,
   // Local keyboard and controller events.
   input logic loc_valid,
   output logic loc_ready,
   input logic [3:0] loc_kind,
   input logic [6:0] loc_d1,
   input logic [6:0] loc_d2,
   input logic loc_arp,
   // Sequencer playback events.
   input logic play_valid,
   output logic play_ready,
   input logic [3:0] play_track,
   input logic [3:0] play_kind,
   input logic [6:0] play_d1,
   input logic [6:0] play_d2,
   // Program and bank dump request.
   input logic dump_req,
   output logic dump_ready,
   // Transmitted channel messages toward the link.
   output logic tx_valid,
   input logic tx_ready,
   output logic [7:0] tx_status,
   output logic [6:0] tx_d1,
   output logic [6:0] tx_d2
);
   import mcr_pkg::*;

   mcr_state_t s_q; // Registered state.
   mcr_state_t s_d; // Next state.
   logic [15:0] rx_mask; // Parts that take the incoming message.
   logic rx_glob; // Incoming message taken on the global channel.
   logic [2:0] rx_fx; // Effects whose control channel matches.
   logic rx_hit; // Anything takes the incoming message.
   logic [15:0] int_mask; // Parts eligible to receive in this mode.

   ////////////////////////////////////////////////////////////////////////////
   // Message filters.

   // True for a bank select controller.
   function automatic logic is_bank(input logic [3:0] k, input logic [6:0] n);
      return k == `MCR_CTRL && (n == `MCR_CC_BANK_MSB || n == `MCR_CC_BANK_LSB);
   endfunction

   // Global enables; they apply to every channel.
   function automatic logic glob_pass(input logic [3:0] k, input logic [6:0] n);
      logic ok;
      ok = 1'b1;
      if (k == `MCR_PROG) begin
         ok = pc_all_en;
      end else if (is_bank(k, n)) begin
         ok = bank_en;
      end else if (k == `MCR_CTRL) begin
         ok = cc_en;
      end else if (k == `MCR_CHAN_PR) begin
         ok = at_en;
      end
      return ok;
   endfunction

   // Global enables combined with the per-part filters of part i.
   function automatic logic part_pass(input logic [3:0] k, input logic [6:0] n, input logic [3:0] i);
      logic ok;
      ok = glob_pass(k, n);
      if (k == `MCR_PROG || is_bank(k, n)) begin
         ok = ok && part_pc_en[i];
      end else if (k == `MCR_CTRL) begin
         // Modulation one first, assignable number next, everything else last.
         if (n == `MCR_CC_MOD1) begin
            ok = ok && stick_up_permit[i];
         end else if (n == asg_cc) begin
            ok = ok && part_asg_en[i];
         end else begin
            ok = ok && part_other_en[i];
         end
      end else if (k == `MCR_CHAN_PR) begin
         ok = ok && part_at_en[i];
      end
      return ok;
   endfunction

   // Program number to program change byte; general banks count from one.
   function automatic logic [6:0] prog_byte(input logic [7:0] num, input logic gen);
      logic [7:0] b;
      b = gen ? num - 8'h01 : num;
      return b[6:0];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.

   // Receive decode, bank pending, and the transmit fan-out engine.
   always_comb begin
      logic [3:0] kind;
      logic [3:0] ch;
      logic ok_kind;
      logic pcb;
      logic elig;
      mcr_part_t pst;
      logic [3:0] pi;
      logic isg;
      logic [3:0] dch;
      logic txset;
      logic dst_ok;
      logic msg_ok;
      logic keep;
      kind = rx_status[7:4];
      ch = rx_status[3:0];
      ok_kind = rx_status[7] && kind != `MCR_SYSTEM;
      pcb = kind == `MCR_PROG || is_bank(kind, rx_d1);
      elig = 1'b0;
      pst = MCR_INTERNAL_ONLY;
      pi = s_q.idx[3:0];
      isg = 1'b0;
      dch = 4'h0;
      txset = 1'b0;
      dst_ok = 1'b0;
      msg_ok = 1'b0;
      keep = 1'b0;
      s_d = s_q;

      // Part matching; in single mode no part receives.
      for (int i = 0; i < 16; i++) begin
         pst = mcr_part_t'(part_status[2*i +: 2]);
         elig = (mode == MCR_MULTI && pst == MCR_INTERNAL_ONLY) ||
                (mode == MCR_SEQ && (pst == MCR_INTERNAL_ONLY || pst == MCR_BOTH_WAYS));
         int_mask[i] = elig;
         rx_mask[i] = rx_valid && ok_kind && elig && part_chan[4*i +: 4] == ch &&
                      part_pass(kind, rx_d1, 4'(i));
      end

      // Global channel acceptance depends on mode and page.
      rx_glob = 1'b0;
      if (rx_valid && ok_kind && ch == global_chan && glob_pass(kind, rx_d1)) begin
         if (mode == MCR_SINGLE) begin
            rx_glob = !pcb || play_page;
         end else if (mode == MCR_MULTI) begin
            // Effect switching rides controllers; combinations need the play page.
            rx_glob = (kind == `MCR_CTRL && !pcb) || (pcb && play_page && combi_change_en);
         end else begin
            rx_glob = kind == `MCR_CTRL && !pcb;
         end
      end
      // A combination switch takes the program change away from the parts.
      if (rx_glob && pcb && mode == MCR_MULTI) begin
         rx_mask = 16'h0000;
      end

      // Effect control channels take controllers outside single mode.
      for (int j = 0; j < 3; j++) begin
         rx_fx[j] = rx_valid && kind == `MCR_CTRL && cc_en && mode != MCR_SINGLE &&
                    effect_control_channel[4*j +: 4] == ch;
      end
      rx_hit = |rx_mask || rx_glob || |rx_fx;

      // Accepted message; anything unmatched leaves no trace.
      s_d.acc_valid = rx_hit;
      s_d.prog_valid = 1'b0;
      if (rx_hit) begin
         s_d.acc_mask = rx_mask;
         s_d.acc_global = rx_glob;
         s_d.acc_fx = rx_fx;
         s_d.acc_status = rx_status;
         s_d.acc_d1 = rx_d1;
         // Release velocity is not interpreted.
         s_d.acc_d2 = kind == `MCR_NOTE_OFF ? 7'h00 : rx_d2;
         if (kind == `MCR_CTRL && rx_d1 == `MCR_CC_BANK_MSB) begin
            s_d.pend[ch][13:7] = rx_d2;
         end else if (kind == `MCR_CTRL && rx_d1 == `MCR_CC_BANK_LSB) begin
            s_d.pend[ch][6:0] = rx_d2;
         end else if (kind == `MCR_PROG) begin
            // Only now does the pending bank take effect.
            s_d.prog_valid = 1'b1;
            s_d.prog_combi = rx_glob && mode == MCR_MULTI;
            s_d.prog_bank = s_q.pend[ch];
            s_d.prog_num = {1'b0, rx_d1} + {7'h00, s_q.pend[ch][13:7] == bank_map_gen_msb};
         end
      end

      // The link takes the current word.
      if (s_q.tx_valid && tx_ready) begin
         s_d.tx_valid = 1'b0;
      end

      case (s_q.st)
         MCR_IDLE: begin
            // Dumps first, playback next, local activity last.
            if (ce && dump_req) begin
               s_d.st = MCR_SEND;
               s_d.src = MCR_SRC_DUMP;
               s_d.idx = 5'h00;
               s_d.ph = 2'h0;
            end else if (ce && play_valid) begin
               s_d.st = MCR_SEND;
               s_d.src = MCR_SRC_PLAY;
               s_d.idx = 5'h00;
               s_d.one = play_track;
               s_d.kind = play_kind;
               s_d.d1 = play_d1;
               s_d.d2 = play_kind == `MCR_NOTE_OFF ? `MCR_REL_VEL : play_d2;
            end else if (ce && loc_valid) begin
               // Local poly pressure never leaves; arpeggio notes stay home without local coupling.
               keep = loc_kind[3] && loc_kind != `MCR_SYSTEM && loc_kind != `MCR_POLY_PR &&
                      !(loc_arp && !local_ctrl_on &&
                        (loc_kind == `MCR_NOTE_ON || loc_kind == `MCR_NOTE_OFF));
               s_d.st = keep ? MCR_SEND : MCR_IDLE;
               s_d.src = MCR_SRC_LOCAL;
               s_d.idx = 5'h00;
               s_d.kind = loc_kind;
               // Bend arrives as low seven bits in d1 and high seven in d2 and goes out so.
               s_d.d1 = loc_d1;
               s_d.d2 = loc_kind == `MCR_NOTE_OFF ? `MCR_REL_VEL : loc_d2;
            end
         end
         MCR_SEND: begin
            // One destination per step while the output word is free.
            if (!s_d.tx_valid) begin
               isg = s_q.idx == `MCR_GLOBAL_IDX;
               dch = isg ? global_chan : part_chan[{pi, 2'b00} +: 4];
               pst = mcr_part_t'(part_status[{pi, 1'b0} +: 2]);
               txset = pst == MCR_EXTERNAL_ONLY || pst == MCR_EXTERNAL_ALT ||
                       (mode == MCR_SEQ && pst == MCR_BOTH_WAYS);
               if (s_q.src == MCR_SRC_LOCAL) begin
                  if (mode == MCR_SINGLE) begin
                     dst_ok = isg;
                  end else if (mode == MCR_MULTI) begin
                     dst_ok = isg || txset;
                  end else begin
                     dst_ok = !isg && pi == sel_track && txset;
                  end
               end else if (s_q.src == MCR_SRC_PLAY) begin
                  dst_ok = !isg && pi == s_q.one && txset;
               end else begin
                  dst_ok = !isg && txset && mode != MCR_SINGLE && pc_all_en && part_pc_en[pi];
               end
               if (isg) begin
                  msg_ok = glob_pass(s_q.kind, s_q.d1) &&
                           (!(s_q.kind == `MCR_PROG || is_bank(s_q.kind, s_q.d1)) || play_page);
               end else begin
                  msg_ok = part_pass(s_q.kind, s_q.d1, pi);
               end
               if (s_q.idx == `MCR_END_IDX) begin
                  s_d.st = MCR_IDLE;
               end else if (s_q.src == MCR_SRC_DUMP) begin
                  // Bank MSB, bank LSB, then the program change.
                  if (dst_ok && s_q.ph == `MCR_PC_PHASE) begin
                     s_d.tx_valid = 1'b1;
                     s_d.tx_status = {`MCR_PROG, dch};
                     s_d.tx_d1 = prog_byte(part_pnum[{pi, 3'b000} +: 8], part_gen[pi]);
                     s_d.tx_d2 = 7'h00;
                  end else if (dst_ok && bank_en) begin
                     s_d.tx_valid = 1'b1;
                     s_d.tx_status = {`MCR_CTRL, dch};
                     s_d.tx_d1 = s_q.ph == 2'h0 ? `MCR_CC_BANK_MSB : `MCR_CC_BANK_LSB;
                     s_d.tx_d2 = s_q.ph == 2'h0 ? part_bank[14*pi + 7 +: 7] : part_bank[14*pi +: 7];
                  end
                  if (!dst_ok || s_q.ph == `MCR_PC_PHASE) begin
                     s_d.ph = 2'h0;
                     s_d.idx = s_q.idx + 5'h01;
                  end else begin
                     s_d.ph = s_q.ph + 2'h1;
                  end
               end else begin
                  if (dst_ok && msg_ok) begin
                     s_d.tx_valid = 1'b1;
                     s_d.tx_status = {s_q.kind, dch};
                     s_d.tx_d1 = s_q.d1;
                     s_d.tx_d2 = s_q.d2;
                  end
                  s_d.idx = s_q.idx + 5'h01;
               end
            end
         end
         default: begin
            s_d.st = MCR_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.

   // The clock enable freezes every field, so pulses stretch while it is low.
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // Requests are taken only in idle; playback and dumps win over local events.
   assign dump_ready = ce && s_q.st == MCR_IDLE;
   assign play_ready = ce && s_q.st == MCR_IDLE && !dump_req;
   assign loc_ready = ce && s_q.st == MCR_IDLE && !dump_req && !play_valid;
   assign tx_valid = s_q.tx_valid;
   assign tx_status = s_q.tx_status;
   assign tx_d1 = s_q.tx_d1;
   assign tx_d2 = s_q.tx_d2;
   assign acc_valid = s_q.acc_valid;
   assign acc_status = s_q.acc_status;
   assign acc_d1 = s_q.acc_d1;
   assign acc_d2 = s_q.acc_d2;
   assign acc_mask = s_q.acc_mask;
   assign acc_global = s_q.acc_global;
   assign acc_fx = s_q.acc_fx;
   assign prog_valid = s_q.prog_valid;
   assign prog_combi = s_q.prog_combi;
   assign prog_bank = s_q.prog_bank;
   assign prog_num = s_q.prog_num;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_poly_not_sent: assert property (tx_valid |-> tx_status[7:4] != `MCR_POLY_PR)
      else $error("poly pressure transmitted");
   a_release_vel_fixed: assert property (tx_valid && tx_status[7:4] == `MCR_NOTE_OFF |-> tx_d2 == `MCR_REL_VEL)
      else $error("note stop sent with a release velocity");
   a_release_vel_ignored: assert property (acc_valid && acc_status[7:4] == `MCR_NOTE_OFF |-> acc_d2 == 7'h00)
      else $error("release velocity passed on");
   a_bank_tx_gate: assert property (tx_valid && is_bank(tx_status[7:4], tx_d1) |-> bank_en)
      else $error("bank select sent while disabled");
   a_cc_tx_gate: assert property (tx_valid && tx_status[7:4] == `MCR_CTRL && !is_bank(tx_status[7:4], tx_d1)
      |-> cc_en)
      else $error("control change sent while disabled");
   a_arp_silent: assert property (ce && loc_ready && loc_valid && loc_arp && !local_ctrl_on &&
      (loc_kind == `MCR_NOTE_ON || loc_kind == `MCR_NOTE_OFF) |=> s_q.st == MCR_IDLE)
      else $error("arpeggio note queued without local coupling");
   a_unmatched_drop: assert property (ce && !rx_hit |=> !acc_valid && !prog_valid)
      else $error("unmatched message had an effect");
   a_multi_int_only: assert property (ce && rx_hit && mode == MCR_MULTI |=> (acc_mask & ~$past(int_mask)) == 16'h0000)
      else $error("part took a message without internal status");
   a_bank_pends: assert property (ce && rx_valid && is_bank(rx_status[7:4], rx_d1) |=> !prog_valid)
      else $error("bank select switched the program by itself");
   a_single_edit_block: assert property (ce && rx_valid && mode == MCR_SINGLE && !play_page &&
      rx_status[7:4] == `MCR_PROG |=> !prog_valid)
      else $error("program change taken on an edit page");
   a_seq_local_chan: assert property (tx_valid && s_q.src == MCR_SRC_LOCAL && mode == MCR_SEQ
      |-> tx_status[3:0] == part_chan[{sel_track, 2'b00} +: 4])
      else $error("sequencer local message on a wrong channel");

   c_multi_fanout: cover property (ce && mode == MCR_MULTI && loc_valid && loc_ready ##[1:40] tx_valid && tx_ready);
   c_dump_pc: cover property (s_q.src == MCR_SRC_DUMP && tx_valid && tx_status[7:4] == `MCR_PROG);
   c_combi_select: cover property (prog_valid && prog_combi);
   c_part_accept: cover property (acc_valid && acc_mask != 16'h0000);
endmodule

// ===== hdl/mcr_regs.svh
// Constants for the channel message router: status nibbles, controller numbers and fixed values.
// Assumes it is included by its bare name from the router.
`ifndef MCR_REGS_SVH
`define MCR_REGS_SVH
`define MCR_NOTE_OFF 4'h8
`define MCR_NOTE_ON 4'h9
`define MCR_POLY_PR 4'ha
`define MCR_CTRL 4'hb
`define MCR_PROG 4'hc
`define MCR_CHAN_PR 4'hd
`define MCR_BEND 4'he
`define MCR_SYSTEM 4'hf
`define MCR_CC_BANK_MSB 7'h00
`define MCR_CC_MOD1 7'h01
`define MCR_CC_BANK_LSB 7'h20
`define MCR_REL_VEL 7'h40
`define MCR_GLOBAL_IDX 5'h10
`define MCR_END_IDX 5'h11
`define MCR_PC_PHASE 2'h2
`endif

// ===== hdl/mcr_pkg.sv
// Types shared by the channel message router.
// Assumes nothing beyond a SystemVerilog compiler.
package mcr_pkg;
   // Operating mode: single sound, layered multi-part, sequencer.
   typedef enum logic [1:0] {MCR_SINGLE = 2'b00, MCR_MULTI = 2'b01, MCR_SEQ = 2'b10} mcr_mode_t;
   // Per-part status as configured for each part or track.
   typedef enum logic [1:0] {
      MCR_INTERNAL_ONLY = 2'b00,
      MCR_BOTH_WAYS = 2'b01,
      MCR_EXTERNAL_ONLY = 2'b10,
      MCR_EXTERNAL_ALT = 2'b11
   } mcr_part_t;
   // Transmit engine state.
   typedef enum logic {MCR_IDLE = 1'b0, MCR_SEND = 1'b1} mcr_tx_st_t;
   // Source of the message being fanned out.
   typedef enum logic [1:0] {MCR_SRC_LOCAL = 2'b00, MCR_SRC_PLAY = 2'b01, MCR_SRC_DUMP = 2'b10} mcr_src_t;
   // Whole state of the router.
   typedef struct packed {
      mcr_tx_st_t st;
      mcr_src_t src;
      logic [4:0] idx;
      logic [1:0] ph;
      logic [3:0] kind;
      logic [6:0] d1;
      logic [6:0] d2;
      logic [3:0] one;
      logic tx_valid;
      logic [7:0] tx_status;
      logic [6:0] tx_d1;
      logic [6:0] tx_d2;
      logic acc_valid;
      logic [15:0] acc_mask;
      logic acc_global;
      logic [2:0] acc_fx;
      logic [7:0] acc_status;
      logic [6:0] acc_d1;
      logic [6:0] acc_d2;
      logic prog_valid;
      logic prog_combi;
      logic [13:0] prog_bank;
      logic [7:0] prog_num;
      logic [15:0][13:0] pend;
   } mcr_state_t;
endpackage

// ===== sim/mcr_ext_dev.sv
// External MIDI device model: it takes the router's transmitted channel messages.
// Assumes the bench seeds $urandom and reads the got queue by hierarchical name.
module mcr_ext_dev (
   // Clock.
   input wire logic clk,
   // Transmit link from the router.
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_status,
   input wire logic [6:0] tx_d1,
   input wire logic [6:0] tx_d2
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [21:0] got[$]; // Messages taken, oldest first, as status, first and second data byte.
   initial tx_ready = 1'b0;
   ////////////////////////////////////////////////////////////////////////////////
   // Random stalls prove that the router holds a message until it is taken.
   always @(posedge clk) begin
      if (tx_valid && tx_ready) begin
         got.push_back({tx_status, tx_d1, tx_d2});
      end
      tx_ready <= #1 ($urandom_range(3) != 0);
   end
endmodule

// ===== sim/tb.sv
// Self-checking bench of the channel message router with a reference model in integers and queues.
// Assumes the design package and the external device model are compiled first.
module tb;
   import mcr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, ce, play_page, local_ctrl_on, pc_all_en, combi_change_en, bank_en, at_en, cc_en;
   logic rx_valid, acc_valid, acc_global, prog_valid, prog_combi, loc_valid, loc_ready, loc_arp;
   logic play_valid, play_ready, dump_req, dump_ready, tx_valid, tx_ready;
   mcr_mode_t mode; // Operating mode under test.
   logic [3:0] global_chan, sel_track, loc_kind, play_track, play_kind;
   logic [6:0] bank_map_gen_msb, asg_cc, rx_d1, rx_d2, acc_d1, acc_d2, loc_d1, loc_d2, play_d1, play_d2;
   logic [6:0] tx_d1, tx_d2;
   logic [7:0] rx_status, acc_status, prog_num, tx_status;
   logic [15:0] part_pc_en, part_at_en, stick_up_permit, part_asg_en, part_other_en, part_gen, acc_mask;
   logic [11:0] effect_control_channel;
   logic [13:0] prog_bank;
   logic [2:0] acc_fx;
   logic [31:0] part_status;
   logic [63:0] part_chan;
   logic [127:0] part_pnum;
   logic [223:0] part_bank;
   int bad_count, samples_checked, seed;
   ////////////////////////////////////////////////////////////////////////////////
   // Design and far-side model; every port is wired so that the bench can steer it.
   mcr_router dut_u (.clk(clk), .rst(rst), .ce(ce), .mode(mode), .global_chan(global_chan),
      .play_page(play_page), .local_ctrl_on(local_ctrl_on), .pc_all_en(pc_all_en),
      .combi_change_en(combi_change_en), .bank_en(bank_en), .at_en(at_en), .cc_en(cc_en),
      .bank_map_gen_msb(bank_map_gen_msb), .sel_track(sel_track), .part_chan(part_chan),
      .part_status(part_status), .part_pc_en(part_pc_en), .part_at_en(part_at_en),
      .stick_up_permit(stick_up_permit), .part_asg_en(part_asg_en), .part_other_en(part_other_en),
      .asg_cc(asg_cc), .effect_control_channel(effect_control_channel), .part_pnum(part_pnum),
      .part_gen(part_gen), .part_bank(part_bank), .rx_valid(rx_valid), .rx_status(rx_status),
      .rx_d1(rx_d1), .rx_d2(rx_d2), .acc_valid(acc_valid), .acc_status(acc_status), .acc_d1(acc_d1),
      .acc_d2(acc_d2), .acc_mask(acc_mask), .acc_global(acc_global), .acc_fx(acc_fx),
      .prog_valid(prog_valid), .prog_combi(prog_combi), .prog_bank(prog_bank), .prog_num(prog_num),
      .loc_valid(loc_valid), .loc_ready(loc_ready), .loc_kind(loc_kind), .loc_d1(loc_d1),
      .loc_d2(loc_d2), .loc_arp(loc_arp), .play_valid(play_valid), .play_ready(play_ready),
      .play_track(play_track), .play_kind(play_kind), .play_d1(play_d1), .play_d2(play_d2),
      .dump_req(dump_req), .dump_ready(dump_ready), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_status(tx_status), .tx_d1(tx_d1), .tx_d2(tx_d2));
   mcr_ext_dev ext_u (.clk(clk), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_status(tx_status),
      .tx_d1(tx_d1), .tx_d2(tx_d2));
   ////////////////////////////////////////////////////////////////////////////////
   // One comparison; wide enough for a whole transmitted message.
   task automatic chk(input string nm, input logic [21:0] e, input logic [21:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // The only place where the run ends.
   task automatic summarize();
      if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Sends one received message; the answer is sampled in the cycle after the taking edge.
   task automatic rx_msg(input logic [7:0] s, input logic [6:0] a, input logic [6:0] b);
      rx_status = s;
      rx_d1 = a;
      rx_d2 = b;
      rx_valid = 1'b1;
      @(posedge clk);
      #1 rx_valid = 1'b0;
   endtask
   // Waits, bounded, until the fan-out engine is idle again.
   task automatic wait_idle();
      int n;
      n = 0;
      while (loc_ready !== 1'b1) begin
         @(posedge clk);
         #1 n++;
         if (n > 300) begin
            bad_count++;
            summarize();
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Clock at 100 ns.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Main sequence: reset, random receive and local traffic, then program selection.
   initial begin
      logic [15:0] m;
      logic [21:0] q[$];
      logic [3:0] ch, k;
      logic [6:0] v;
      {rst, ce, play_page, local_ctrl_on, pc_all_en, combi_change_en, bank_en, at_en, cc_en} = 9'h1ff;
      {rx_valid, loc_valid, loc_arp, play_valid, dump_req} = 5'h00;
      {play_track, play_kind, play_d1, play_d2, rx_status, rx_d1, rx_d2} = 44'h0;
      {loc_kind, loc_d1, loc_d2, global_chan, sel_track} = 26'h0;
      mode = MCR_MULTI;
      seed = $urandom(32'h6bcf3af5);
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      chk("acc_valid", 0, acc_valid);
      chk("tx_valid", 0, tx_valid);
      repeat (40) begin
         // Fresh random configuration of every part.
         mode = ($urandom_range(1) != 0) ? MCR_SEQ : MCR_MULTI;
         {part_chan, part_status, global_chan, sel_track, bank_map_gen_msb} =
            111'({$urandom, $urandom, $urandom, $urandom});
         {part_pc_en, part_at_en, stick_up_permit, part_asg_en, part_other_en, part_gen} = {$urandom, $urandom, $urandom};
         {asg_cc, effect_control_channel, part_pnum, part_bank} = 371'({$urandom, $urandom, $urandom, $urandom,
            $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
         // Receive a note; note stop carries no velocity inward.
         k = ($urandom_range(1) != 0) ? 4'h8 : 4'h9;
         ch = 4'($urandom);
         v = 7'($urandom_range(127, 1));
         m = 16'h0;
         for (int i = 0; i < 16; i++) begin
            if (part_chan[4*i+:4] == ch && (mode == MCR_MULTI ? part_status[2*i+:2] == 2'b00 : !part_status[2*i+1]))
               m[i] = 1'b1;
         end
         rx_msg({k, ch}, v, v);
         chk("acc_valid", m != 0, acc_valid);
         if (m != 0) begin
            chk("acc_mask", m, acc_mask);
            chk("acc_d2", (k == 4'h8) ? 0 : v, acc_d2);
         end
         // Local note start or bend, fanned out to every sending destination in index order.
         loc_kind = ($urandom_range(1) != 0) ? 4'he : 4'h9;
         {loc_d1, loc_d2} = 14'($urandom);
         q.delete();
         for (int i = 0; i < 16; i++) begin
            if (mode == MCR_MULTI ? part_status[2*i+1] : (i == sel_track && part_status[2*i+:2] != 2'b00))
               q.push_back({loc_kind, part_chan[4*i+:4], loc_d1, loc_d2});
         end
         if (mode == MCR_MULTI) q.push_back({loc_kind, global_chan, loc_d1, loc_d2});
         ext_u.got.delete();
         loc_valid = 1'b1;
         wait_idle();
         @(posedge clk);
         #1 loc_valid = 1'b0;
         wait_idle();
         chk("tx_count", q.size(), ext_u.got.size());
         foreach (q[j]) if (j < ext_u.got.size()) chk("tx_msg", q[j], ext_u.got[j]);
      end
      // Single mode: pending bank then program change; general bank counts from one; edit page ignores.
      mode = MCR_SINGLE;
      for (int c = 0; c < 3; c++) begin
         play_page = (c != 2);
         v = 7'($urandom);
         rx_msg({4'hb, global_chan}, 7'h00, bank_map_gen_msb + 7'(c == 1));
         chk("prog_valid", 0, prog_valid);
         rx_msg({4'hc, global_chan}, v, 7'h00);
         chk("prog_valid", c != 2, prog_valid);
         if (c != 2) chk("prog_num", {1'b0, v} + 8'(c == 0), prog_num);
      end
      // An arpeggio note without local coupling leaves nothing on the link.
      {local_ctrl_on, loc_arp, loc_kind} = 6'h19;
      ext_u.got.delete();
      loc_valid = 1'b1;
      @(posedge clk);
      #1 loc_valid = 1'b0;
      wait_idle();
      chk("tx_count", 0, ext_u.got.size());
      summarize();
   end
endmodule
